/* File: design/bcu_branch_condition_unit.sv */
// Behaviour
// R1: Condition flags are eight 4-bit fields, bits 32 to 63, field zero first.
// R2: Fields load from general register under mask, another field, or exception bits 32-35.
// R3: Record forms write 100 negative, 010 positive, 001 zero, plus summary overflow.
// R4: Zero compare uses 64 bits in 64-bit mode, low 32 bits in 32-bit mode.
// R5: Undefined result may leave field zero comparison bits undefined.
// R6: Field zero bits flag negative, positive, zero, and final summary overflow.
// R7: Compares write less, greater, equal, overflow into chosen field; short forms use field zero.
// R8: Wide immediate compares take field number from the wide field select.
// R9: Short bit test immediate updates field zero.
// R10: Branch target least significant bit is forced to zero.
// R11: Target is address plus displacement, return address, or loop counter.
// R12: Save-return writes next instruction address to return register, taken or not.
// R13: Wide branches test bits 32-47 only; short branches test bits 32-35 only.
// R14: Tested bit is condition bit at test-bit select plus 32.
// R15: Counter decrement spans 64 bits in 64-bit mode, low 32 in 32-bit mode.
// R16: Wide option picks false, true, decrement-nonzero or decrement-zero branching.
// R17: Short option 0 branches on false, 1 branches on true.
// R18: Short service call and interrupt returns act as their standard forms.
// R19: Return address is instruction address plus 2 for short, plus 4 for wide.
// R20: Displacements of 24, 15, 8 bits get a zero appended, sign-extend, add.
// R21: Register-sourced targets use bits 0-62 with zero appended, bit 62 unmasked.
// R22: Wide option encoding 00 false, 01 true, 10 decrement nonzero, 11 decrement zero.
`timescale 1ns/1ps
`default_nettype none
module bcu_branch_condition_unit
  import bcu_pkg::*;
#(
  parameter int ADDR_W = 64 // Instruction address width
) (
  input wire logic i_core_clk, // Core clock
  input wire logic i_reset, // Synchronous reset, high
  input wire logic i_mode64, // 1 for 64-bit mode
  // Condition flag register operations
  input wire logic i_cr_valid, // Condition op strobe
  input wire bcu_cr_op_t i_cr_op, // Condition op kind
  input wire logic [31:0] i_gpr_value, // Source general register low word
  input wire logic [7:0] i_field_mask, // Field mask, bit 7 is field zero
  input wire logic [2:0] i_src_field, // Source field for field copy
  input wire logic [2:0] i_dst_field, // Destination field (normal select)
  input wire logic [1:0] i_wide_field_select, // Destination for wide immediate compares
  input wire bcu_cmp_form_t i_cmp_form, // Compare field-select form
  input wire logic i_cmp_signed, // Signed compare ordering
  input wire logic [63:0] i_op_a, // Compare left operand / record result
  input wire logic [63:0] i_op_b, // Compare right operand
  input wire logic i_result_undef, // Result partly undefined
  input wire logic i_bit_test_hit, // Bit test outcome (nonzero)
  input wire logic [3:0] i_fixed_point_exception_reg, // Exception bits 32..35
  input wire logic i_summary_ovf, // Summary overflow at completion
  // Branch operations
  input wire logic i_br_valid, // Branch strobe
  input wire bcu_br_kind_t i_br_kind, // Branch kind
  input wire bcu_tgt_src_t i_tgt_src, // Target source
  input wire bcu_disp_t i_disp_kind, // Displacement width
  input wire logic [23:0] i_disp, // Displacement, low-aligned
  input wire logic [ADDR_W-1:0] i_insn_addr, // Branch instruction address
  input wire logic i_insn_short, // 16-bit instruction
  input wire logic i_save_return_flag, // Link requested
  input wire logic [3:0] i_wide_test_bit_select, // Wide test bit select
  input wire logic [1:0] i_short_test_bit_select, // Short test bit select
  input wire bcu_bo_t i_wide_branch_option, // Wide branch option
  input wire logic i_short_branch_option, // Short branch option
  input wire logic [ADDR_W-1:0] i_save_restore_addr0, // Save/restore address 0
  input wire logic [ADDR_W-1:0] i_service_vector, // Service call vector
  input wire logic i_lr_wr, // Software write of return register
  input wire logic i_ctr_wr, // Software write of loop counter
  input wire logic [ADDR_W-1:0] i_spr_wdata, // Software write data
  output logic [31:0] o_condition_flags, // Condition flag register
  output logic [ADDR_W-1:0] o_return_address_reg, // Return address register
  output logic [ADDR_W-1:0] o_loop_counter_reg, // Loop counter register
  output logic o_br_taken, // Redirect fetch (registered pulse)
  output logic [ADDR_W-1:0] o_br_target, // Redirect address
  output logic o_service_call, // Service call raised (pulse)
  output logic o_int_return // Interrupt return performed (pulse)
);

  // Architected state and the branch datapath around it
  logic [31:0] cr_r;
  logic [31:0] cr_nxt;
  logic [ADDR_W-1:0] lr_r;
  logic [ADDR_W-1:0] ctr_r;
  logic [ADDR_W-1:0] ctr_dec;
  logic [ADDR_W-1:0] tgt_raw;
  logic [ADDR_W-1:0] disp_ext;
  logic [ADDR_W-1:0] link_addr;
  logic [3:0] cmp_code;
  logic [2:0] rec_code;
  logic [2:0] dest_field;
  logic ctr_zero;
  logic cond_bit;
  logic take;
  logic dec_ctr;
  logic taken_r;
  logic [ADDR_W-1:0] target_r;
  logic svc_r;
  logic iret_r;

  // Field n occupies bits 32+4n..35+4n; packed index 31 is bit 32
  function automatic logic [31:0] put_field(input logic [31:0] cr, input logic [2:0] f,
                                            input logic [3:0] v);
    logic [31:0] res;
    res = cr;
    res[31-4*f -: 4] = v; // R1
    return res;
  endfunction

  // Record form: signed zero compare on full or low word
  always_comb begin
    logic signed [63:0] s64;
    logic signed [31:0] s32;
    s64 = i_op_a;
    s32 = i_op_a[31:0];
    if (i_mode64) begin // R4
      rec_code = (s64 < 0) ? BCU_CODE_NEG : ((s64 > 0) ? BCU_CODE_POS : BCU_CODE_ZERO); // R3
    end else begin
      rec_code = (s32 < 0) ? BCU_CODE_NEG : ((s32 > 0) ? BCU_CODE_POS : BCU_CODE_ZERO); // R3
    end
  end

  // Compare flags; width follows mode, ordering follows instruction
  always_comb begin
    logic lt;
    logic gt;
    logic signed [63:0] a64;
    logic signed [63:0] b64;
    // Defaults first so no path can infer a latch
    lt = 1'b0;
    gt = 1'b0;
    a64 = i_mode64 ? i_op_a : {{32{i_op_a[31]}}, i_op_a[31:0]};
    b64 = i_mode64 ? i_op_b : {{32{i_op_b[31]}}, i_op_b[31:0]};
    if (i_cmp_signed) begin
      lt = a64 < b64;
      gt = a64 > b64;
    end else if (i_mode64) begin
      lt = i_op_a < i_op_b;
      gt = i_op_a > i_op_b;
    end else begin
      lt = i_op_a[31:0] < i_op_b[31:0];
      gt = i_op_a[31:0] > i_op_b[31:0];
    end
    cmp_code = {lt, gt, ~lt & ~gt, i_summary_ovf}; // R7
  end

  // Destination field of a compare
  always_comb begin
    unique case (i_cmp_form)
      BCU_CMP_WIDE_SEL: dest_field = {1'b0, i_wide_field_select}; // R8
      BCU_CMP_NORM_SEL: dest_field = i_dst_field; // R7
      BCU_CMP_SHORT: dest_field = 3'h0; // R7
      default: dest_field = 3'h0;
    endcase
  end

  // Next condition flag value
  always_comb begin
    cr_nxt = cr_r;
    if (i_cr_valid) begin
      unique case (i_cr_op)
        BCU_CR_MOVE_GPR: begin
          // Fields whose mask bit is clear keep their old value
          for (int f = 0; f < BCU_NUM_FIELDS; f++) begin
            if (i_field_mask[7-f]) begin
              cr_nxt[31-4*f -: 4] = i_gpr_value[31-4*f -: 4]; // R2
            end
          end
        end
        BCU_CR_MOVE_FIELD: cr_nxt = put_field(cr_r, i_dst_field, cr_r[31-4*i_src_field -: 4]); // R2
        BCU_CR_MOVE_FXER: cr_nxt = put_field(cr_r, i_dst_field, i_fixed_point_exception_reg); // R2
        // Undefined results keep old compare bits; only overflow updates
        BCU_CR_RECORD: cr_nxt = put_field(cr_r, 3'h0,
            i_result_undef ? {cr_r[31:29], i_summary_ovf} : {rec_code, i_summary_ovf}); // R3 R5 R6
        BCU_CR_COMPARE: cr_nxt = put_field(cr_r, dest_field, cmp_code); // R7
        BCU_CR_BITTEST: cr_nxt = put_field(cr_r, 3'h0,
            {(i_bit_test_hit ? BCU_CODE_POS : BCU_CODE_ZERO), i_summary_ovf}); // R9
        default: cr_nxt = cr_r;
      endcase
    end
  end

  // Condition flag register
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cr_r <= BCU_CR_RESET;
    end else begin
      cr_r <= cr_nxt;
    end
  end

  // Tested bit: select plus 32; short form only reaches field zero
  always_comb begin
    if (i_br_kind == BCU_BR_SHORT_COND) begin
      cond_bit = cr_r[31 - {3'h0, i_short_test_bit_select}]; // R13 R14
    end else begin
      cond_bit = cr_r[31 - {1'b0, i_wide_test_bit_select}]; // R13 R14
    end
  end

  // Counter decrement and zero test over mode width
  assign ctr_dec = ctr_r - {{(ADDR_W-1){1'b0}}, 1'b1}; // R15
  assign ctr_zero = i_mode64 ? (ctr_dec == '0) : (ctr_dec[31:0] == 32'h0000_0000); // R15

  // Taken decision
  always_comb begin
    take = 1'b0;
    dec_ctr = 1'b0;
    unique case (i_br_kind)
      BCU_BR_UNCOND, BCU_BR_SERVICE, BCU_BR_INT_RETURN: take = 1'b1;
      BCU_BR_WIDE_COND: begin
        unique case (i_wide_branch_option)
          BCU_BO_FALSE: take = ~cond_bit; // R16 R22
          BCU_BO_TRUE: take = cond_bit; // R16 R22
          BCU_BO_DEC_NZ: begin
            dec_ctr = 1'b1;
            take = ~ctr_zero; // R16 R22
          end
          BCU_BO_DEC_Z: begin
            dec_ctr = 1'b1;
            take = ctr_zero; // R16 R22
          end
        endcase
      end
      BCU_BR_SHORT_COND: take = i_short_branch_option ? cond_bit : ~cond_bit; // R17
      default: take = 1'b0;
    endcase
  end

  // Sign-extended displacement with appended zero
  always_comb begin
    unique case (i_disp_kind)
      BCU_DISP_LONG: disp_ext = ADDR_W'({{(ADDR_W-25){i_disp[23]}}, i_disp[23:0], 1'b0}); // R20
      BCU_DISP_MID: disp_ext = ADDR_W'({{(ADDR_W-16){i_disp[14]}}, i_disp[14:0], 1'b0}); // R20
      BCU_DISP_SHORT: disp_ext = ADDR_W'({{(ADDR_W-9){i_disp[7]}}, i_disp[7:0], 1'b0}); // R20
      default: disp_ext = '0;
    endcase
  end

  // Raw target; register sources keep bit 62 (alignment only drops bit 63)
  always_comb begin
    if (i_br_kind == BCU_BR_SERVICE) begin
      tgt_raw = i_service_vector; // R18
    end else if (i_br_kind == BCU_BR_INT_RETURN) begin
      tgt_raw = i_save_restore_addr0; // R18 R21
    end else begin
      unique case (i_tgt_src)
        BCU_TGT_REL: tgt_raw = i_insn_addr + disp_ext; // R11 R20
        BCU_TGT_RETURN: tgt_raw = lr_r; // R11 R21
        BCU_TGT_COUNTER: tgt_raw = ctr_r; // R11 R21
        default: tgt_raw = i_insn_addr;
      endcase
    end
  end

  // Link address wraps silently at the top of the address space
  assign link_addr = i_insn_addr + ADDR_W'(i_insn_short ? BCU_LINK_INC16 : BCU_LINK_INC32); // R19

  // Return address register; target already formed from old value
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      lr_r <= '0;
    end else if (i_br_valid && i_save_return_flag &&
                 i_br_kind != BCU_BR_SERVICE && i_br_kind != BCU_BR_INT_RETURN) begin
      lr_r <= link_addr; // R12
    end else if (i_lr_wr) begin
      lr_r <= i_spr_wdata;
    end
  end

  // Loop counter; 32-bit mode decrement leaves high word untouched
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ctr_r <= '0;
    end else if (i_br_valid && dec_ctr) begin
      if (i_mode64) begin
        ctr_r <= ctr_dec; // R15
      end else begin
        ctr_r <= {ctr_r[ADDR_W-1:32], ctr_dec[31:0]}; // R15
      end
    end else if (i_ctr_wr) begin
      ctr_r <= i_spr_wdata;
    end
  end

  // Redirect outputs, one cycle after the branch
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      taken_r <= 1'b0;
      target_r <= '0;
      svc_r <= 1'b0;
      iret_r <= 1'b0;
    end else begin
      taken_r <= i_br_valid && take;
      target_r <= {tgt_raw[ADDR_W-1:1], 1'b0}; // R10
      svc_r <= i_br_valid && i_br_kind == BCU_BR_SERVICE; // R18
      iret_r <= i_br_valid && i_br_kind == BCU_BR_INT_RETURN; // R18
    end
  end

  // Outputs come straight from flip-flops
  assign o_condition_flags = cr_r;
  assign o_return_address_reg = lr_r;
  assign o_loop_counter_reg = ctr_r;
  assign o_br_taken = taken_r;
  assign o_br_target = target_r;
  assign o_service_call = svc_r;
  assign o_int_return = iret_r;

  // Checks on the registered results, one cycle after each request
  a_target_aligned: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_br_taken |-> o_br_target[0] == 1'b0) else $error("branch target odd"); // R10
  a_record_zero: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_cr_valid && i_cr_op == BCU_CR_RECORD && !i_result_undef && !i_mode64
      && i_op_a[31:0] == 32'h0000_0000 |=> o_condition_flags[31:29] == 3'b001)
    else $error("record zero code wrong"); // R3
  a_record_ovf: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_cr_valid && i_cr_op == BCU_CR_RECORD |=> o_condition_flags[28] == $past(i_summary_ovf))
    else $error("summary overflow not copied"); // R6
  a_short_cmp_f0: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_cr_valid && i_cr_op == BCU_CR_COMPARE && i_cmp_form == BCU_CMP_SHORT
      |=> o_condition_flags[27:0] == $past(cr_r[27:0]))
    else $error("short compare touched other field"); // R7
  a_link_value: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_br_valid && i_save_return_flag && i_insn_short && i_br_kind == BCU_BR_UNCOND
      |=> o_return_address_reg == $past(i_insn_addr) + BCU_LINK_INC16)
    else $error("short link address wrong"); // R12 R19
  a_link_untaken: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_br_valid && i_save_return_flag && !i_insn_short && i_br_kind == BCU_BR_WIDE_COND
      |=> o_return_address_reg == $past(i_insn_addr) + BCU_LINK_INC32)
    else $error("wide link address wrong"); // R12 R19
  a_ctr_decrement: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_br_valid && i_br_kind == BCU_BR_WIDE_COND && i_wide_branch_option[1] && !i_mode64
      |=> o_loop_counter_reg[31:0] == $past(ctr_r[31:0]) - 32'h0000_0001)
    else $error("counter not decremented"); // R15
  a_short_option: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_br_valid && i_br_kind == BCU_BR_SHORT_COND
      |=> o_br_taken == ($past(i_short_branch_option) == $past(cr_r[31 - i_short_test_bit_select])))
    else $error("short branch decision wrong"); // R14 R17
  a_counter_target: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_br_valid && i_br_kind == BCU_BR_UNCOND && i_tgt_src == BCU_TGT_COUNTER
      |=> o_br_target[ADDR_W-1:1] == $past(ctr_r[ADDR_W-1:1]))
    else $error("counter target wrong"); // R11 R21
endmodule // bcu_branch_condition_unit
`default_nettype wire

/* File: design/bcu_pkg.sv */
package bcu_pkg;
  // Condition flag register geometry
  localparam int BCU_FIELD_W = 4;
  localparam int BCU_NUM_FIELDS = 8;
  localparam int BCU_CR_W = 32;
  localparam logic [31:0] BCU_CR_RESET = 32'h0000_0000;
  // Bit positions inside a field, numbered from the field's first bit (bit 32 side)
  localparam int BCU_POS_LESS = 0;
  localparam int BCU_POS_GREATER = 1;
  localparam int BCU_POS_ZERO = 2;
  localparam int BCU_POS_SUMMARY = 3;
  // Record-form codes for the three comparison bits
  localparam logic [2:0] BCU_CODE_NEG = 3'h4;
  localparam logic [2:0] BCU_CODE_POS = 3'h2;
  localparam logic [2:0] BCU_CODE_ZERO = 3'h1;
  // Mode offset for the counter and compare width
  localparam int BCU_MODE64_OFS = 0;
  localparam int BCU_MODE32_OFS = 32;
  // Link increments
  localparam logic [63:0] BCU_LINK_INC16 = 64'h0000_0000_0000_0002;
  localparam logic [63:0] BCU_LINK_INC32 = 64'h0000_0000_0000_0004;
  // Test-bit select widths
  localparam int BCU_WIDE_BI_W = 4;
  localparam int BCU_SHORT_BI_W = 2;

  // Condition flag register operations
  typedef enum logic [2:0] {
    BCU_CR_NONE,
    BCU_CR_MOVE_GPR,
    BCU_CR_MOVE_FIELD,
    BCU_CR_MOVE_FXER,
    BCU_CR_RECORD,
    BCU_CR_COMPARE,
    BCU_CR_BITTEST
  } bcu_cr_op_t;

  // Compare flavour and field-select source
  typedef enum logic [1:0] {
    BCU_CMP_WIDE_SEL,
    BCU_CMP_NORM_SEL,
    BCU_CMP_SHORT
  } bcu_cmp_form_t;

  // Branch target source
  typedef enum logic [1:0] {
    BCU_TGT_REL,
    BCU_TGT_RETURN,
    BCU_TGT_COUNTER
  } bcu_tgt_src_t;

  // Displacement width
  typedef enum logic [1:0] {
    BCU_DISP_LONG,
    BCU_DISP_MID,
    BCU_DISP_SHORT
  } bcu_disp_t;

  // Wide branch option encoding
  typedef enum logic [1:0] {
    BCU_BO_FALSE = 2'h0,
    BCU_BO_TRUE = 2'h1,
    BCU_BO_DEC_NZ = 2'h2,
    BCU_BO_DEC_Z = 2'h3
  } bcu_bo_t;

  // Branch kinds
  typedef enum logic [2:0] {
    BCU_BR_NONE,
    BCU_BR_UNCOND,
    BCU_BR_WIDE_COND,
    BCU_BR_SHORT_COND,
    BCU_BR_SERVICE,
    BCU_BR_INT_RETURN
  } bcu_br_kind_t;
endpackage

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bcu_pkg::*;
  // Every input has a quiet value at time zero
  logic i_core_clk = 1'b0, i_reset = 1'b1, i_mode64 = 1'b1, i_cr_valid = 1'b0;
  logic i_cmp_signed = 1'b0, i_result_undef = 1'b0, i_bit_test_hit = 1'b0;
  logic i_summary_ovf = 1'b0, i_br_valid = 1'b0, i_insn_short = 1'b0, i_lr_wr = 1'b0;
  logic i_save_return_flag = 1'b0, i_short_branch_option = 1'b0, i_ctr_wr = 1'b0;
  logic [31:0] i_gpr_value = 32'h0000_0000;
  logic [7:0] i_field_mask = 8'h00;
  logic [2:0] i_src_field = 3'h0, i_dst_field = 3'h0;
  logic [1:0] i_wide_field_select = 2'h0, i_short_test_bit_select = 2'h0;
  logic [3:0] i_fixed_point_exception_reg = 4'h0, i_wide_test_bit_select = 4'h0;
  logic [23:0] i_disp = 24'h00_0000;
  logic [63:0] i_op_a = '0, i_op_b = '0, i_insn_addr = '0, i_save_restore_addr0 = '0;
  logic [63:0] i_service_vector = '0, i_spr_wdata = '0;
  bcu_cr_op_t i_cr_op = BCU_CR_NONE;
  bcu_cmp_form_t i_cmp_form = BCU_CMP_SHORT;
  bcu_br_kind_t i_br_kind = BCU_BR_NONE;
  bcu_tgt_src_t i_tgt_src = BCU_TGT_REL;
  bcu_disp_t i_disp_kind = BCU_DISP_LONG;
  bcu_bo_t i_wide_branch_option = BCU_BO_FALSE;
  logic [31:0] o_condition_flags;
  logic [63:0] o_return_address_reg, o_loop_counter_reg, o_br_target;
  logic o_br_taken, o_service_call, o_int_return;
  // Expected copies of the architected registers
  logic [31:0] cr_e = '0;
  logic [63:0] lr_e = '0, ctr_e = '0;
  logic [63:0] ra [5] = '{64'hFFFF_FFFF_FFFF_FFFF, 64'h0000_0000_8000_0000,
    64'h0000_0000_8000_0000, 64'h0000_0001_0000_0000, 64'h0000_0001_0000_0000};
  logic [23:0] dv [3] = '{24'h80_0001, 24'h00_4003, 24'h00_007F};
  int n_errors = 0, compares = 0;

  bcu_branch_condition_unit #(.ADDR_W(64)) dut (
    .i_core_clk, .i_reset, .i_mode64, .i_cr_valid, .i_cr_op, .i_gpr_value, .i_field_mask,
    .i_src_field, .i_dst_field, .i_wide_field_select, .i_cmp_form, .i_cmp_signed, .i_op_a,
    .i_op_b, .i_result_undef, .i_bit_test_hit, .i_fixed_point_exception_reg, .i_summary_ovf,
    .i_br_valid, .i_br_kind, .i_tgt_src, .i_disp_kind, .i_disp, .i_insn_addr, .i_insn_short,
    .i_save_return_flag, .i_wide_test_bit_select, .i_short_test_bit_select,
    .i_wide_branch_option, .i_short_branch_option, .i_save_restore_addr0, .i_service_vector,
    .i_lr_wr, .i_ctr_wr, .i_spr_wdata, .o_condition_flags, .o_return_address_reg,
    .o_loop_counter_reg, .o_br_taken, .o_br_target, .o_service_call, .o_int_return
  );

  // 20 MHz core clock
  initial begin
    forever #25 i_core_clk = ~i_core_clk;
  end

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_cr(input logic [31:0] g);
    chk("condition_flags", {32'h0, cr_e}, {32'h0, g});
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  function automatic void setf(input int f, input logic [3:0] v);
    cr_e[31 - 4 * f -: 4] = v;
  endfunction

  // Signed or unsigned three-way order; 32-bit mode looks at the low word only
  function automatic logic [2:0] cmp3(input logic [63:0] a, input logic [63:0] b, input logic s);
    logic [64:0] x, y;
    x = i_mode64 ? {s & a[63], a} : {{33{s & a[31]}}, a[31:0]};
    y = i_mode64 ? {s & b[63], b} : {{33{s & b[31]}}, b[31:0]};
    if ($signed(x) < $signed(y)) return 3'h4;
    if ($signed(x) > $signed(y)) return 3'h2;
    return 3'h1;
  endfunction

  function automatic logic [63:0] rel_tgt();
    logic [63:0] s;
    case (i_disp_kind)
      BCU_DISP_LONG: s = {{39{i_disp[23]}}, i_disp, 1'b0};
      BCU_DISP_MID: s = {{48{i_disp[14]}}, i_disp[14:0], 1'b0};
      default: s = {{55{i_disp[7]}}, i_disp[7:0], 1'b0};
    endcase
    return (i_insn_addr + s) & ~64'h1;
  endfunction

  // Strobe stays up so successive calls run back to back; idle drops it
  task automatic cr_do(input bcu_cr_op_t op);
    i_cr_op = op;
    i_cr_valid = 1'b1;
    @(negedge i_core_clk);
    chk_cr(o_condition_flags);
  endtask

  task automatic idle(input string nm);
    i_cr_valid = 1'b0;
    i_br_valid = 1'b0;
    @(negedge i_core_clk);
    $display("Test %s done", nm);
  endtask

  task automatic spr(input logic lw, input logic cw, input logic [63:0] d);
    i_lr_wr = lw;
    i_ctr_wr = cw;
    i_spr_wdata = d;
    @(negedge i_core_clk);
    i_lr_wr = 1'b0;
    i_ctr_wr = 1'b0;
    @(negedge i_core_clk);
    if (lw) lr_e = d;
    if (cw) ctr_e = d;
    chk("return_address_reg", lr_e, o_return_address_reg);
    chk("loop_counter_reg", ctr_e, o_loop_counter_reg);
  endtask

  task automatic cmp_do(input bcu_cmp_form_t fm, input logic s, input logic [63:0] a,
                        input logic [63:0] b);
    int f;
    i_cmp_form = fm;
    i_cmp_signed = s;
    i_op_a = a;
    i_op_b = b;
    i_summary_ovf = ~i_summary_ovf;
    f = (fm == BCU_CMP_WIDE_SEL) ? int'(i_wide_field_select) :
        (fm == BCU_CMP_NORM_SEL) ? int'(i_dst_field) : 0;
    setf(f, {cmp3(a, b, s), i_summary_ovf});
    cr_do(BCU_CR_COMPARE);
  endtask

  // The decision comes from the bench's own flags and counter, not the outputs
  task automatic br_go(input bcu_br_kind_t k, input logic [63:0] tgt);
    logic c, z, t;
    logic [63:0] n;
    c = (k == BCU_BR_SHORT_COND) ? cr_e[31 - i_short_test_bit_select] :
        cr_e[31 - i_wide_test_bit_select];
    n = i_mode64 ? ctr_e - 64'h1 : {ctr_e[63:32], ctr_e[31:0] - 32'h1};
    z = i_mode64 ? (n == '0) : (n[31:0] == '0);
    t = (k == BCU_BR_WIDE_COND) ? (i_wide_branch_option[1] ? z == i_wide_branch_option[0] :
        c == i_wide_branch_option[0]) : (k == BCU_BR_SHORT_COND) ? c == i_short_branch_option : 1'b1;
    if (k == BCU_BR_WIDE_COND && i_wide_branch_option[1]) ctr_e = n;
    if (i_save_return_flag && k != BCU_BR_SERVICE && k != BCU_BR_INT_RETURN)
      lr_e = i_insn_addr + (i_insn_short ? BCU_LINK_INC16 : BCU_LINK_INC32);
    i_br_kind = k;
    i_br_valid = 1'b1;
    @(negedge i_core_clk);
    chk("br_taken", {63'h0, t}, {63'h0, o_br_taken});
    if (t) chk("br_target", tgt, o_br_target);
    chk("return_address_reg", lr_e, o_return_address_reg);
    chk("loop_counter_reg", ctr_e, o_loop_counter_reg);
    chk("service_call", {63'h0, k == BCU_BR_SERVICE}, {63'h0, o_service_call});
    chk("int_return", {63'h0, k == BCU_BR_INT_RETURN}, {63'h0, o_int_return});
  endtask

  // Main sequence
  initial begin
    repeat (2) @(negedge i_core_clk);
    i_reset = 1'b0;
    chk_cr(o_condition_flags);
    chk("loop_counter_reg", ctr_e, o_loop_counter_reg);
    idle("reset");
    i_gpr_value = 32'h1234_5678;
    i_field_mask = 8'hA5;
    for (int f = 0; f < 8; f++) begin
      if (i_field_mask[7 - f]) setf(f, i_gpr_value[31 - 4 * f -: 4]);
    end
    cr_do(BCU_CR_MOVE_GPR);
    i_src_field = 3'h2;
    i_dst_field = 3'h3;
    setf(3, cr_e[23:20]);
    cr_do(BCU_CR_MOVE_FIELD);
    i_fixed_point_exception_reg = 4'hB;
    i_dst_field = 3'h6;
    setf(6, 4'hB);
    cr_do(BCU_CR_MOVE_FXER);
    idle("field moves");
    // Same results seen through both widths give different signs
    for (int i = 0; i < 5; i++) begin
      i_mode64 = (i != 2 && i != 3);
      i_op_a = ra[i];
      i_summary_ovf = i[0];
      setf(0, {cmp3(i_op_a, '0, 1'b1), i_summary_ovf});
      cr_do(BCU_CR_RECORD);
    end
    i_result_undef = 1'b1;
    i_summary_ovf = 1'b1;
    setf(0, {cr_e[31:29], 1'b1});
    cr_do(BCU_CR_RECORD);
    i_result_undef = 1'b0;
    i_bit_test_hit = 1'b1;
    setf(0, {3'h2, i_summary_ovf});
    cr_do(BCU_CR_BITTEST);
    i_bit_test_hit = 1'b0;
    setf(0, {3'h1, i_summary_ovf});
    cr_do(BCU_CR_BITTEST);
    idle("record and bit test");
    // Wide and normal selects differ so a swapped source shows
    i_wide_field_select = 2'h2;
    i_dst_field = 3'h5;
    cmp_do(BCU_CMP_WIDE_SEL, 1'b1, '1, 64'h1);
    cmp_do(BCU_CMP_NORM_SEL, 1'b0, '1, 64'h1);
    cmp_do(BCU_CMP_SHORT, 1'b1, 64'h5, 64'h5);
    i_mode64 = 1'b0;
    cmp_do(BCU_CMP_NORM_SEL, 1'b1, 64'h0000_0001_0000_0000, '0);
    i_mode64 = 1'b1;
    idle("compares");
    i_gpr_value = 32'hA5C3_0F96;
    i_field_mask = 8'hFF;
    cr_e = i_gpr_value;
    cr_do(BCU_CR_MOVE_GPR);
    idle("flag load");
    // Odd base address so the forced low target bit is visible
    i_insn_addr = 64'h0000_0000_0010_0001;
    for (int k = 0; k < 3; k++) begin
      i_disp_kind = bcu_disp_t'(k);
      i_disp = dv[k];
      i_insn_short = (k == 2);
      i_save_return_flag = (k != 1);
      br_go(BCU_BR_UNCOND, rel_tgt());
    end
    idle("relative branches");
    i_insn_short = 1'b0;
    i_save_return_flag = 1'b0;
    i_disp_kind = BCU_DISP_MID;
    spr(1'b0, 1'b1, 64'h3);
    // Counter runs 3 down past zero; decrement-nonzero is taken both times, decrement-zero goes each way
    for (int b = 0; b < 4; b++) begin
      for (int s = 0; s < 2; s++) begin
        i_wide_branch_option = bcu_bo_t'(b);
        i_wide_test_bit_select = s ? 4'hD : 4'h2;
        br_go(BCU_BR_WIDE_COND, rel_tgt());
      end
    end
    idle("wide conditions");
    i_mode64 = 1'b0;
    spr(1'b0, 1'b1, 64'h0000_0001_0000_0001);
    i_wide_branch_option = BCU_BO_DEC_Z;
    i_save_return_flag = 1'b1;
    br_go(BCU_BR_WIDE_COND, rel_tgt());
    i_save_return_flag = 1'b0;
    i_insn_short = 1'b1;
    i_disp_kind = BCU_DISP_SHORT;
    for (int i = 0; i < 8; i++) begin
      i_short_branch_option = i[2];
      i_short_test_bit_select = i[1:0];
      br_go(BCU_BR_SHORT_COND, rel_tgt());
    end
    i_mode64 = 1'b1;
    idle("counter and short conditions");
    spr(1'b1, 1'b0, 64'h4000_0000_0000_0007);
    spr(1'b0, 1'b1, 64'h8000_0000_0000_0003);
    // Target is formed from the old return register before the link lands
    i_tgt_src = BCU_TGT_RETURN;
    i_save_return_flag = 1'b1;
    i_insn_short = 1'b0;
    br_go(BCU_BR_UNCOND, lr_e & ~64'h1);
    i_tgt_src = BCU_TGT_COUNTER;
    br_go(BCU_BR_UNCOND, ctr_e & ~64'h1);
    i_service_vector = 64'h0000_0000_0000_0C00;
    br_go(BCU_BR_SERVICE, i_service_vector);
    i_save_restore_addr0 = 64'h0000_0000_1234_5673;
    br_go(BCU_BR_INT_RETURN, 64'h0000_0000_1234_5672);
    idle("register targets and system calls");
    report_and_stop();
  end

  // Watchdog; the sequence needs only about sixty cycles
  initial begin
    #(50 * 2000);
    n_errors++;
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
